// ### tb/cdcfg_host_model.sv
// host-side model of the control port: issues byte register accesses to the configuration bank
// assumes one clock, requests taken on the rising edge, read data valid just after that edge
`timescale 1ns/1ps
module cdcfg_host_model (
    input wire logic clk,
    output cdcfg_pkg::cdcfg_req_type reg_req,
    input wire logic [7:0] reg_rdata
);
    // ==========================================
    // request driving
    // bus idle at time zero
    initial
    begin
        reg_req = '0;
    end

    // one access: driven after a falling edge, held through the taking edge, data taken just after it
    task automatic access(input logic [7:0] addr, input logic wr, input logic rd, input logic [7:0] data,
                          output logic [7:0] rdata);
        logic wr_ok;
        wr_ok = wr;
        // reserved playback filter code is never sent
        if (wr && addr == cdcfg_pkg::CDCFG_PLAY_PROC_OFS && data[7:6] == 2'b11)
        begin
            wr_ok = 1'b0;
        end
        @(negedge clk);
        reg_req.addr = addr;
        reg_req.wdata = data;
        reg_req.wr_en = wr_ok;
        reg_req.rd_en = rd;
        @(posedge clk);
        #1;
        rdata = reg_rdata;
    endtask

    // release: strobes low, released fields show inverted last value
    task automatic idle();
        @(negedge clk);
        reg_req.wr_en = 1'b0;
        reg_req.rd_en = 1'b0;
        reg_req.addr = ~reg_req.addr;
        reg_req.wdata = ~reg_req.wdata;
    endtask
endmodule

// ### tb/codec_dsp_config_channel_enable_test.sv
// self-checking bench of the configuration bank: register access, decoded paths, ganged volumes
// assumes the host model in its own file and the bank with four channels
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module codec_dsp_config_channel_enable_test;
    // ==========================================
    // signals
    logic clk; // bench clock
    logic rst_n; // synchronous reset, active low
    cdcfg_pkg::cdcfg_req_type reg_req; // access from host model
    logic [7:0] reg_rdata; // read answer
    logic reg_hit; // mapped offset flag
    logic [3:0][7:0] rec_vol_in; // record volume inputs
    logic [3:0][7:0] play_vol_in; // playback volume inputs
    logic [3:0][7:0] record_volume; // effective record volumes
    logic [3:0][7:0] playback_volume; // effective playback volumes
    cdcfg_pkg::cdcfg_path_type record_path; // decoded record settings
    cdcfg_pkg::cdcfg_path_type playback_path; // decoded playback settings
    logic input_one_enable, input_two_enable, input_three_enable, input_four_enable;
    logic output_one_enable, output_two_enable, output_three_enable, output_four_enable;
    int error_cnt; // mismatches
    int n_checks; // comparisons
    logic [7:0] d; // scratch read data

    // ==========================================
    // instances
    cdcfg_host_model host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
    cdcfg_top #(.CHANNELS(4)) uut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .record_channel_volume(rec_vol_in), .playback_channel_volume(play_vol_in),
        .record_path(record_path), .playback_path(playback_path), .record_volume(record_volume),
        .playback_volume(playback_volume), .input_one_enable(input_one_enable),
        .input_two_enable(input_two_enable), .input_three_enable(input_three_enable),
        .input_four_enable(input_four_enable), .output_one_enable(output_one_enable),
        .output_two_enable(output_two_enable), .output_three_enable(output_three_enable),
        .output_four_enable(output_four_enable));

    // 25 ns clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================
    // helpers
    // decoded settings expected from a processing byte
    function automatic cdcfg_pkg::cdcfg_path_type exp_path(input logic [7:0] b);
        cdcfg_pkg::cdcfg_path_type p;
        p.filter_response = cdcfg_pkg::cdcfg_filt_type'(b[7:6]);
        p.filter_reserved = (b[7:6] == 2'b11);
        p.highpass_select = cdcfg_pkg::cdcfg_hpf_type'(b[5:4]);
        p.highpass_programmable = (b[5:4] == 2'b00);
        p.biquad_enable = 3'(((1 << b[3:2]) - 1)); // thermometer, stage 0 at lsb
        p.soft_step_enable = ~b[1];
        p.volume_gang = b[0];
        return p;
    endfunction

    // write one byte and release the bus
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.access(a, 1'b1, 1'b0, v, d);
        host.idle();
    endtask

    // read one byte and compare
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.access(a, 1'b0, 1'b1, 8'h00, d);
        `CHK("reg_rdata", e, d)
        host.idle();
    endtask

    // compare every decoded output against the three register values
    task automatic chk_all(input logic [7:0] rc, input logic [7:0] pc, input logic [7:0] ch);
        repeat (2) @(posedge clk);
        #1;
        `CHK("record_path", exp_path(rc), record_path)
        `CHK("playback_path", exp_path(pc), playback_path)
        `CHK("inputs", ch[7:4], {input_one_enable, input_two_enable, input_three_enable, input_four_enable})
        `CHK("outputs", ch[3:0], {output_one_enable, output_two_enable, output_three_enable, output_four_enable})
        for (int c = 0; c < 4; c++)
        begin
            `CHK("record_volume", (rc[0] && ch[7-c]) ? rec_vol_in[0] : rec_vol_in[c], record_volume[c])
            `CHK("playback_volume", (pc[0] && ch[3-c]) ? play_vol_in[0] : play_vol_in[c], playback_volume[c])
        end
    endtask

    // synchronous reset held for six cycles
    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
    endtask

    // counts, verdict, end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========================================
    // watchdog
    initial
    begin
        #(25 * 4000);
        error_cnt++;
        give_verdict();
    end

    // ==========================================
    // tests
    initial
    begin
        error_cnt = 0;
        n_checks = 0;
        rst_n = 1'b0;
        rec_vol_in = {8'h44, 8'h33, 8'h22, 8'h11};
        play_vol_in = {8'hC4, 8'hC3, 8'hC2, 8'hC1};
        do_reset();
        // reset values of registers and outputs
        rd_chk(8'h72, 8'h18);
        rd_chk(8'h73, 8'h18);
        rd_chk(8'h76, 8'hCC);
        chk_all(8'h18, 8'h18, 8'hCC);
        $display("test reset_values done");
        // every filter code (playback 0-2 only), highpass and biquad code, soft-step and gang both ways
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h72, {2'(i), 2'(3 - i), 2'(i), i[0], i[1]});
            wr(8'h73, {2'(i == 3 ? 2 : i), 2'(i + 1), 2'(3 - i), i[1], i[0]});
            rd_chk(8'h72, {2'(i), 2'(3 - i), 2'(i), i[0], i[1]});
            rd_chk(8'h73, {2'(i == 3 ? 2 : i), 2'(i + 1), 2'(3 - i), i[1], i[0]});
            chk_all({2'(i), 2'(3 - i), 2'(i), i[0], i[1]}, {2'(i == 3 ? 2 : i), 2'(i + 1), 2'(3 - i), i[1], i[0]},
                8'hCC);
        end
        $display("test field_codes done");
        // ganged volumes follow channel enables, channel one itself disabled on one path in every case
        for (int k = 0; k < 8; k++)
        begin
            @(negedge clk);
            rec_vol_in[k % 4] = 8'h50 + 8'(k);
            play_vol_in[k % 4] = 8'hA0 + 8'(k);
        end
        wr(8'h72, 8'h19);
        wr(8'h73, 8'h19);
        wr(8'h76, 8'h5A);
        chk_all(8'h19, 8'h19, 8'h5A);
        wr(8'h76, 8'hA5);
        chk_all(8'h19, 8'h19, 8'hA5);
        wr(8'h72, 8'h18);
        chk_all(8'h18, 8'h19, 8'hA5);
        $display("test gang_volume done");
        // unmapped offset, hit flag, back-to-back writes, write and read together
        host.access(8'h74, 1'b1, 1'b0, 8'h5A, d);
        `CHK("reg_hit", 1'b0, reg_hit)
        host.access(8'h76, 1'b1, 1'b0, 8'h30, d);
        `CHK("reg_hit", 1'b1, reg_hit)
        host.access(8'h74, 1'b0, 1'b1, 8'h00, d);
        `CHK("unmapped", 8'h00, d)
        host.access(8'h73, 1'b1, 1'b1, 8'h25, d);
        `CHK("old_value", 8'h19, d)
        host.idle();
        rd_chk(8'h73, 8'h25);
        chk_all(8'h18, 8'h25, 8'h30);
        $display("test port_edges done");
        // mid-run reset restores every register
        do_reset();
        rd_chk(8'h76, 8'hCC);
        rd_chk(8'h73, 8'h18);
        chk_all(8'h18, 8'h18, 8'hCC);
        $display("test reset_again done");
        give_verdict();
    end
endmodule

// ### verilog/cdcfg_path_decode.sv
// decoder for one processing path: settings byte plus channel volumes to clocked controls
// assumes synchronous reset and inputs steady in the clock domain
`timescale 1ns/1ps
module cdcfg_path_decode #(
    parameter int CHANNELS = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] cfg,
    input wire logic [CHANNELS-1:0] chan_enable,
    input wire logic [CHANNELS-1:0][7:0] volume_in,
    output cdcfg_pkg::cdcfg_path_type path,
    output logic [CHANNELS-1:0][7:0] volume_out
);

    // ==========================================
    // parameter check
    if (CHANNELS < 1)
    begin : g_chan_check
        $error("channel count must be at least one");
    end

    // ==========================================
    // state
    cdcfg_pkg::cdcfg_path_type path_r; // decoded controls
    cdcfg_pkg::cdcfg_path_type path_nxt;
    logic [CHANNELS-1:0][7:0] vol_r; // effective volumes
    logic [CHANNELS-1:0][7:0] vol_nxt;
    logic [1:0] bq_code; // biquad count field

    // thermometer mask: stage i runs when count exceeds i
    function automatic logic [2:0] bq_mask(input logic [1:0] code);
        logic [2:0] m;
        m = 3'h0;
        for (int i = 0; i < 3; i++)
        begin
            m[i] = (code > i[1:0]);
        end
        return m;
    endfunction

    // next-value computation
    always_comb
    begin
        bq_code = cfg[cdcfg_pkg::CDCFG_BQ_LSB +: 2];
        path_nxt.filter_response = cdcfg_pkg::cdcfg_filt_type'(cfg[cdcfg_pkg::CDCFG_FILT_LSB +: 2]);
        path_nxt.filter_reserved = (cfg[cdcfg_pkg::CDCFG_FILT_LSB +: 2] == cdcfg_pkg::CDCFG_FILT_RSVD);
        path_nxt.highpass_select = cdcfg_pkg::cdcfg_hpf_type'(cfg[cdcfg_pkg::CDCFG_HPF_LSB +: 2]);
        path_nxt.highpass_programmable = (cfg[cdcfg_pkg::CDCFG_HPF_LSB +: 2] == cdcfg_pkg::CDCFG_HPF_PROG);
        path_nxt.biquad_enable = bq_mask(bq_code);
        path_nxt.soft_step_enable = ~cfg[cdcfg_pkg::CDCFG_SOFT_BIT];
        path_nxt.volume_gang = cfg[cdcfg_pkg::CDCFG_GANG_BIT];
        // ganged: active channels take channel one, powered or not
        for (int c = 0; c < CHANNELS; c++)
        begin
            if (cfg[cdcfg_pkg::CDCFG_GANG_BIT] && chan_enable[c])
            begin
                vol_nxt[c] = volume_in[0];
            end
            else
            begin
                vol_nxt[c] = volume_in[c];
            end
        end
    end

    // registers: controls reset to the reset-value decode, volumes reset to zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            path_r <= '{cdcfg_pkg::CDCFG_FILT_LINEAR, 1'b0, cdcfg_pkg::CDCFG_HPF_CUT_TINY, 1'b0, 3'h3, 1'b1, 1'b0};
            vol_r <= '0;
        end
        else
        begin
            path_r <= path_nxt;
            vol_r <= vol_nxt;
        end
    end

    assign path = path_r;
    assign volume_out = vol_r;

    // ==========================================
    // checks
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rst_n);

    biquad_mask_a: assert property ($past(rst_n) |-> path.biquad_enable == bq_mask($past(cfg[3:2])))
        else $error("biquad stage mask does not match count");
    soft_step_a: assert property ($past(rst_n) |-> path.soft_step_enable != $past(cfg[1]))
        else $error("soft-step enable not inverse of disable bit");
    gang_volume_a: assert property (cfg[0] && chan_enable[CHANNELS-1] |=>
        volume_out[CHANNELS-1] == $past(volume_in[0]))
        else $error("ganged active channel not using channel one volume");
    hpf_prog_a: assert property ($past(rst_n) |-> path.highpass_programmable == ($past(cfg[5:4]) == 2'b00))
        else $error("programmable highpass flag wrong");

endmodule

// ### verilog/cdcfg_pkg.sv
// constants, field layouts and carrier types of the codec processing configuration bank
// assumes a control-port decoder (serial bus target) that presents byte-wide register accesses
//
// Overview of operation
// - record biquad count zero to three, resets two
// - record soft-step disable, ramps when clear, reset 0
// - record gang makes active channels use channel one
// - playback filter response codes 0-2, resets linear
// - playback highpass code 0 programmable, else fixed
// - playback biquad count zero to three, resets two
// - playback soft-step disable set means immediate steps
// - playback gang makes active channels use channel one
// - enable bits 7-4 enable inputs, reset 1100
// - enable bits 3-0 enable outputs, reset 1100
// - record filter response bits 7-6, code 3 reserved
// - record highpass bits 5-4, resets code 1
package cdcfg_pkg;

    // ==========================================
    // register offsets
    localparam logic [7:0] CDCFG_REC_PROC_OFS = 8'h72; // record processing configuration
    localparam logic [7:0] CDCFG_PLAY_PROC_OFS = 8'h73; // playback processing configuration
    localparam logic [7:0] CDCFG_CHAN_EN_OFS = 8'h76; // channel enable configuration

    // ==========================================
    // reset values
    localparam logic [7:0] CDCFG_REC_PROC_RST = 8'h18; // linear, hpf 1, two biquads
    localparam logic [7:0] CDCFG_PLAY_PROC_RST = 8'h18; // linear, hpf 1, two biquads
    localparam logic [7:0] CDCFG_CHAN_EN_RST = 8'hCC; // channels one and two on
    localparam logic [7:0] CDCFG_UNMAPPED_DATA = 8'h00; // read answer for other offsets

    // ==========================================
    // processing register field positions
    localparam int CDCFG_FILT_LSB = 6; // filter response, two bits
    localparam int CDCFG_HPF_LSB = 4; // highpass select, two bits
    localparam int CDCFG_BQ_LSB = 2; // biquad count, two bits
    localparam int CDCFG_SOFT_BIT = 1; // soft-step disable
    localparam int CDCFG_GANG_BIT = 0; // volume gang

    // ==========================================
    // channel enable register field positions
    localparam int CDCFG_IN_EN_LSB = 4; // input enables, four bits, channel one at msb
    localparam int CDCFG_OUT_EN_LSB = 0; // output enables, four bits, channel one at msb

    // ==========================================
    // encodings
    typedef enum logic [1:0] {
        CDCFG_FILT_LINEAR = 2'b00, // linear phase
        CDCFG_FILT_LOW = 2'b01, // low latency
        CDCFG_FILT_ULTRA = 2'b10, // ultra-low latency
        CDCFG_FILT_RSVD = 2'b11 // reserved code, stored as written
    } cdcfg_filt_type;

    typedef enum logic [1:0] {
        CDCFG_HPF_PROG = 2'b00, // programmable first-order iir
        CDCFG_HPF_CUT_TINY = 2'b01, // 0.00002 x fs
        CDCFG_HPF_CUT_SMALL = 2'b10, // 0.00025 x fs
        CDCFG_HPF_CUT_LARGE = 2'b11 // 0.002 x fs
    } cdcfg_hpf_type;

    // decoded settings of one processing path
    typedef struct packed {
        cdcfg_filt_type filter_response; // filter response selection
        logic filter_reserved; // reserved response code present
        cdcfg_hpf_type highpass_select; // highpass selection
        logic highpass_programmable; // custom iir in use
        logic [2:0] biquad_enable; // per-stage enables, stage 0 at lsb
        logic soft_step_enable; // ramp volume, mute, unmute
        logic volume_gang; // channel-one volume for enabled channels
    } cdcfg_path_type;

    // byte-wide register access from the control port
    typedef struct packed {
        logic [7:0] addr; // register offset
        logic wr_en; // write strobe, one cycle
        logic rd_en; // read strobe, one cycle
        logic [7:0] wdata; // write data
    } cdcfg_req_type;

endpackage

// ### verilog/cdcfg_top.sv
// codec processing configuration bank: three byte registers and their decoded controls
// assumes the control-port decoder issues one-cycle read and write strobes with a byte offset
`timescale 1ns/1ps
module cdcfg_top #(
    parameter int CHANNELS = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire cdcfg_pkg::cdcfg_req_type reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    input wire logic [CHANNELS-1:0][7:0] record_channel_volume,
    input wire logic [CHANNELS-1:0][7:0] playback_channel_volume,
    output cdcfg_pkg::cdcfg_path_type record_path,
    output cdcfg_pkg::cdcfg_path_type playback_path,
    output logic [CHANNELS-1:0][7:0] record_volume,
    output logic [CHANNELS-1:0][7:0] playback_volume,
    output logic input_one_enable,
    output logic input_two_enable,
    output logic input_three_enable,
    output logic input_four_enable,
    output logic output_one_enable,
    output logic output_two_enable,
    output logic output_three_enable,
    output logic output_four_enable
);

    // ==========================================
    // parameter check
    if (CHANNELS != 4)
    begin : g_chan_check
        $error("channel enable register serves exactly four channels");
    end

    // ==========================================
    // register state
    logic [7:0] rec_cfg_r; // record processing configuration
    logic [7:0] rec_cfg_nxt;
    logic [7:0] play_cfg_r; // playback processing configuration
    logic [7:0] play_cfg_nxt;
    logic [7:0] chan_en_r; // channel enable configuration
    logic [7:0] chan_en_nxt;
    logic [7:0] rdata_r; // read answer
    logic [7:0] rdata_nxt;
    logic [7:0] sel_data; // addressed register contents
    logic [3:0] in_en; // input enables, channel one at lsb
    logic [3:0] out_en; // output enables, channel one at lsb

    // offset decode used only for the hit flag
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == cdcfg_pkg::CDCFG_REC_PROC_OFS) || (a == cdcfg_pkg::CDCFG_PLAY_PROC_OFS) ||
            (a == cdcfg_pkg::CDCFG_CHAN_EN_OFS);
    endfunction

    // ==========================================
    // register write and read paths
    // next values: a write updates exactly the addressed byte
    always_comb
    begin
        rec_cfg_nxt = rec_cfg_r;
        play_cfg_nxt = play_cfg_r;
        chan_en_nxt = chan_en_r;
        rdata_nxt = rdata_r;
        sel_data = cdcfg_pkg::CDCFG_UNMAPPED_DATA;
        // contents seen by a read, before any same-cycle write
        unique case (1'b1)
            reg_req.addr == cdcfg_pkg::CDCFG_REC_PROC_OFS: sel_data = rec_cfg_r;
            reg_req.addr == cdcfg_pkg::CDCFG_PLAY_PROC_OFS: sel_data = play_cfg_r;
            reg_req.addr == cdcfg_pkg::CDCFG_CHAN_EN_OFS: sel_data = chan_en_r;
            default: sel_data = cdcfg_pkg::CDCFG_UNMAPPED_DATA;
        endcase
        if (reg_req.wr_en)
        begin
            // every bit is stored as written, reserved filter code included
            if (reg_req.addr == cdcfg_pkg::CDCFG_REC_PROC_OFS)
            begin
                rec_cfg_nxt = reg_req.wdata;
            end
            if (reg_req.addr == cdcfg_pkg::CDCFG_PLAY_PROC_OFS)
            begin
                play_cfg_nxt = reg_req.wdata;
            end
            if (reg_req.addr == cdcfg_pkg::CDCFG_CHAN_EN_OFS)
            begin
                chan_en_nxt = reg_req.wdata;
            end
        end
        if (reg_req.rd_en)
        begin
            rdata_nxt = sel_data;
        end
    end

    // registers, synchronous reset to documented values
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rec_cfg_r <= cdcfg_pkg::CDCFG_REC_PROC_RST;
            play_cfg_r <= cdcfg_pkg::CDCFG_PLAY_PROC_RST;
            chan_en_r <= cdcfg_pkg::CDCFG_CHAN_EN_RST;
            rdata_r <= cdcfg_pkg::CDCFG_UNMAPPED_DATA;
        end
        else
        begin
            rec_cfg_r <= rec_cfg_nxt;
            play_cfg_r <= play_cfg_nxt;
            chan_en_r <= chan_en_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // handshake: offset hit is combinational
    assign reg_hit = is_mapped(reg_req.addr);
    assign reg_rdata = rdata_r;

    // ==========================================
    // channel enables
    // register msb is channel one; reorder to channel one at lsb
    always_comb
    begin
        for (int c = 0; c < 4; c++)
        begin
            in_en[c] = chan_en_r[cdcfg_pkg::CDCFG_IN_EN_LSB + 3 - c];
            out_en[c] = chan_en_r[cdcfg_pkg::CDCFG_OUT_EN_LSB + 3 - c];
        end
    end

    // enables come straight from the register flip-flops
    assign input_one_enable = in_en[0];
    assign input_two_enable = in_en[1];
    assign input_three_enable = in_en[2];
    assign input_four_enable = in_en[3];
    assign output_one_enable = out_en[0];
    assign output_two_enable = out_en[1];
    assign output_three_enable = out_en[2];
    assign output_four_enable = out_en[3];

    // ==========================================
    // path decoders
    // record path, ganged over enabled inputs
    cdcfg_path_decode #(
        .CHANNELS(CHANNELS)
    ) u_rec (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(rec_cfg_r),
        .chan_enable(in_en),
        .volume_in(record_channel_volume),
        .path(record_path),
        .volume_out(record_volume)
    );

    // playback path, ganged over enabled outputs
    cdcfg_path_decode #(
        .CHANNELS(CHANNELS)
    ) u_play (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(play_cfg_r),
        .chan_enable(out_en),
        .volume_in(playback_channel_volume),
        .path(playback_path),
        .volume_out(playback_volume)
    );

    // ==========================================
    // checks
    default clocking tcb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // write of record and channel enable registers, read of playback register
    sequence rec_write_s;
        reg_req.wr_en && reg_req.addr == cdcfg_pkg::CDCFG_REC_PROC_OFS;
    endsequence
    sequence chan_write_s;
        reg_req.wr_en && reg_req.addr == cdcfg_pkg::CDCFG_CHAN_EN_OFS;
    endsequence
    sequence play_read_s;
        reg_req.rd_en && reg_req.addr == cdcfg_pkg::CDCFG_PLAY_PROC_OFS && !reg_req.wr_en;
    endsequence

    reset_values_a: assert property ($rose(rst_n) |-> rec_cfg_r == cdcfg_pkg::CDCFG_REC_PROC_RST &&
        play_cfg_r == cdcfg_pkg::CDCFG_PLAY_PROC_RST && chan_en_r == cdcfg_pkg::CDCFG_CHAN_EN_RST)
        else $error("registers not at reset values after reset");
    reset_enables_a: assert property ($rose(rst_n) |-> input_one_enable && input_two_enable &&
        !input_three_enable && !input_four_enable && output_one_enable && output_two_enable &&
        !output_three_enable && !output_four_enable)
        else $error("channel enables wrong after reset");
    rec_store_a: assert property (rec_write_s |=> rec_cfg_r == $past(reg_req.wdata))
        else $error("record configuration write not stored");
    chan_enable_a: assert property (chan_write_s ##1 !reg_req.wr_en |-> input_one_enable == $past(reg_req.wdata[7], 1)
        && output_four_enable == $past(reg_req.wdata[0], 1))
        else $error("channel enable outputs do not follow written bits");
    play_read_a: assert property (play_read_s ##1 !reg_req.wr_en |-> reg_rdata == play_cfg_r)
        else $error("playback configuration read back wrong");
    unmapped_read_a: assert property (reg_req.rd_en && !reg_hit |=> reg_rdata == cdcfg_pkg::CDCFG_UNMAPPED_DATA)
        else $error("unmapped offset did not read zero");
    regs_hold_a: assert property (!reg_req.wr_en |=> $stable(rec_cfg_r) && $stable(play_cfg_r) &&
        $stable(chan_en_r))
        else $error("register changed without a write");
    play_filter_a: assert property ($past(rst_n) ##1 rst_n |->
        playback_path.filter_response == $past(play_cfg_r[7:6]))
        else $error("playback filter response does not follow register");
    rec_bq_follow_a: assert property (rec_write_s ##1 !reg_req.wr_en |=> record_path.biquad_enable ==
        ($past(reg_req.wdata[3:2], 2) == 2'b00 ? 3'h0 : $past(reg_req.wdata[3:2], 2) == 2'b01 ? 3'h1 :
        $past(reg_req.wdata[3:2], 2) == 2'b10 ? 3'h3 : 3'h7))
        else $error("record biquad stages not updated two cycles after write");

endmodule
